// ==== rtl/mlp_port.sv ====
// local request port of the sdram controller: requests, writes, refresh
`timescale 1ns/1ps
`default_nettype none
module mlp_port
	import mlp_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ctrl_reset_n,
	input  wire logic              user_refresh_en,
	input  wire logic              write_req,
	input  wire logic              read_req,
	input  wire logic              burst_begin,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic [LW_W-1:0]   write_data,
	input  wire logic [LM_W-1:0]   write_byte_mask,
	input  wire logic [CNT_W-1:0]  burst_count,
	input  wire logic              auto_precharge_req,
	input  wire logic              refresh_req,
	input  wire logic [RANK_W-1:0] refresh_rank,
	output logic                   ready,
	output logic                   refresh_ack,
	output mlp_cmd_s               cmd,
	output logic                   cmd_valid,
	input  wire logic              cmd_ready,
	output mlp_beat_s              mem_beat,
	output logic                   mem_beat_valid,
	input  wire logic              mem_beat_ready
);

	// sequencing state
	mlp_state_e       state;          // idle or inside a write burst
	mlp_state_e       next_state;
	logic [CNT_W-1:0] left;           // write beats still owed
	logic [CNT_W-1:0] next_left;

	// command register
	mlp_cmd_s         next_cmd;
	logic             next_cmd_valid;

	// handshake outputs
	logic             next_ready;
	logic             next_ack;

	// decoded requests of this cycle
	logic             acc_wr;         // write beat taken
	logic             acc_rd;         // read request taken
	logic             rfsh_pend;      // usable refresh request
	logic             slot_free;      // command register free
	logic [CNT_W-1:0] len;            // burst length in range

	// write word path
	logic             wpush;          // push word into buffer
	mlp_word_s        wword;          // word and mask
	logic             wspace_next;    // buffer space next cycle
	logic             wfifo_ready;    // buffer can take now
	logic             wq_valid;       // buffer head valid
	mlp_word_s        wq_word;        // buffer head
	logic             wq_ready;       // splitter takes head
	logic [LW_W+LM_W-1:0] wq_bits;    // head as raw bits

	// transfers only count while ready is high
	assign acc_wr = ready && write_req;
	// a read colliding with a write is dropped
	assign acc_rd = ready && read_req && !write_req;

	// refresh needs enable and at least one rank
	assign rfsh_pend = user_refresh_en && refresh_req && (refresh_rank != '0);

	// command register empties this edge or is empty
	assign slot_free = !cmd_valid || cmd_ready;

	// count as captured on the first beat
	assign len = mlp_len(burst_count);

	// the mask rides only with write words
	assign wword.data = write_data;
	assign wword.mask = write_byte_mask;

	// head of the word buffer as a struct
	assign wq_word = mlp_word_s'(wq_bits);

	// next sequencing state and command
	always_comb begin
		next_state     = state;
		next_left      = left;
		next_cmd       = cmd;
		next_cmd_valid = cmd_valid;
		next_ack       = 1'b0;
		wpush          = 1'b0;
		// controller took the command
		if (cmd_valid && cmd_ready) begin
			next_cmd_valid = 1'b0;
		end
		unique case (state)
			ST_IDLE: begin
				if (acc_wr && burst_begin) begin
					// first beat of a write burst
					next_cmd.kind    = CMD_WRITE;
					next_cmd.addr    = address;
					next_cmd.count   = len;
					next_cmd.ranks   = '0;
					next_cmd.autopch = auto_precharge_req;
					next_cmd_valid   = 1'b1;
					wpush            = 1'b1;
					// more beats follow unless single
					if (len != BURST_MIN) begin
						next_state = ST_WBURST;
						next_left  = len - BURST_MIN;
					end
				end else if (acc_rd && burst_begin) begin
					// read start with its address
					next_cmd.kind    = CMD_READ;
					next_cmd.addr    = address;
					next_cmd.count   = len;
					next_cmd.ranks   = '0;
					next_cmd.autopch = auto_precharge_req;
					next_cmd_valid   = 1'b1;
				end else if (!ready && rfsh_pend && slot_free && ctrl_reset_n) begin
					// refresh served while ready is held low
					next_cmd.kind    = CMD_REFRESH;
					next_cmd.addr    = '0;
					next_cmd.count   = BURST_MIN;
					next_cmd.ranks   = refresh_rank;
					next_cmd.autopch = 1'b0;
					next_cmd_valid   = 1'b1;
					next_ack         = 1'b1;
				end
				// beats without burst begin are ignored
			end
			ST_WBURST: begin
				if (acc_wr) begin
					// later beat, burst begin ignored here
					wpush     = 1'b1;
					next_left = left - BURST_MIN;
					// last beat closes the burst
					if (left == BURST_MIN) begin
						next_state = ST_IDLE;
					end
				end
			end
		endcase
	end

	// ready for the coming cycle
	always_comb begin
		if (!ctrl_reset_n) begin
			// nothing taken under controller reset
			next_ready = 1'b0;
		end else if (next_state == ST_WBURST) begin
			// a running burst finishes before any refresh
			next_ready = wspace_next;
		end else begin
			// new request needs command slot and word space
			next_ready = !next_cmd_valid && wspace_next && !rfsh_pend;
		end
	end

	// register sequencing state and outputs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state       <= ST_IDLE;
			left        <= '0;
			cmd         <= '0;
			cmd_valid   <= 1'b0;
			ready       <= RST_READY;
			refresh_ack <= RST_ACK;
		end else begin
			state       <= next_state;
			left        <= next_left;
			cmd         <= next_cmd;
			cmd_valid   <= next_cmd_valid;
			ready       <= next_ready;
			refresh_ack <= next_ack;
		end
	end

	// two-entry word buffer; a memory stall backs up into ready
	mlp_fifo #(
		.WIDTH(LW_W + LM_W),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (wpush),
		.in_data   (wword),
		.in_ready  (wfifo_ready),
		.space_next(wspace_next),
		.out_valid (wq_valid),
		.out_data  (wq_bits),
		.out_ready (wq_ready)
	);

	// word to memory beats
	mlp_split u_split (
		.clock     (clock),
		.rst       (rst),
		.word      (wq_word),
		.word_valid(wq_valid),
		.word_ready(wq_ready),
		.beat      (mem_beat),
		.beat_valid(mem_beat_valid),
		.beat_ready(mem_beat_ready)
	);

	// wfifo_ready is always high on a push, as ready
	// was raised only when space was assured
	// master owns the refresh schedule; no refresh is
	// made here on its own

endmodule
`default_nettype wire

// ==== rtl/mlp_pkg.sv ====
// shared constants, types and helpers of the local request port
package mlp_pkg;

	localparam int DQ_W   = 16;           // memory data bus width
	localparam int LW_W   = 2 * DQ_W;     // local word, full rate
	localparam int LM_W   = LW_W / 8;     // local byte mask bits
	localparam int DM_W   = DQ_W / 8;     // memory data mask bits
	localparam int ADDR_W = 24;           // local word address
	localparam int RANK_W = 2;            // chip selects
	localparam int CNT_W  = 7;            // burst count width
	localparam int FIFO_DEPTH = 2;        // write word buffer

	localparam logic [CNT_W-1:0] BURST_MIN = 7'h01; // shortest burst
	localparam logic [CNT_W-1:0] BURST_MAX = 7'h40; // longest burst
	localparam logic             RST_READY = 1'b0;  // ready at reset
	localparam logic             RST_ACK   = 1'b0;  // ack at reset

	// command kinds handed to the controller
	typedef enum logic [1:0] {
		CMD_NONE    = 2'b00,
		CMD_READ    = 2'b01,
		CMD_WRITE   = 2'b10,
		CMD_REFRESH = 2'b11
	} mlp_cmd_e;

	// port sequencing states
	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_WBURST = 1'b1
	} mlp_state_e;

	// one command towards the controller
	typedef struct packed {
		mlp_cmd_e          kind;    // what to do
		logic [ADDR_W-1:0] addr;    // start address
		logic [CNT_W-1:0]  count;   // beats
		logic [RANK_W-1:0] ranks;   // refresh targets
		logic              autopch; // auto-precharge wanted
	} mlp_cmd_s;

	// one local write word with its byte mask
	typedef struct packed {
		logic [LW_W-1:0] data;
		logic [LM_W-1:0] mask;
	} mlp_word_s;

	// one memory-side write beat
	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [DM_W-1:0] memory_data_mask;
	} mlp_beat_s;

	// active-high byte mask to active-low memory mask
	function automatic logic [DM_W-1:0] mlp_dm_of(input logic [DM_W-1:0] m);
		return ~m;
	endfunction

	// keep a burst count inside the supported range
	function automatic logic [CNT_W-1:0] mlp_len(input logic [CNT_W-1:0] c);
		if (c < BURST_MIN)
			return BURST_MIN;
		if (c > BURST_MAX)
			return BURST_MAX;
		return c;
	endfunction

endpackage

// ==== rtl/mlp_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mlp_fifo
	import mlp_pkg::*;
#(
	parameter int WIDTH = 36,           // word width
	parameter int DEPTH = FIFO_DEPTH    // entries
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  space_next,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer bits
	localparam int CW = $clog2(DEPTH + 1);               // level bits
	localparam logic [CW-1:0] FULL = CW'(DEPTH);         // full level

	logic [WIDTH-1:0] mem      [DEPTH]; // storage
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [PW-1:0]    wp;               // write index
	logic [PW-1:0]    next_wp;
	logic [PW-1:0]    rp;               // read index
	logic [PW-1:0]    next_rp;
	logic [CW-1:0]    cnt;              // entries held
	logic [CW-1:0]    next_cnt;
	logic             push;
	logic             pop;

	// advance an index with wrap
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready   = cnt < FULL;
	assign out_valid  = cnt != '0;
	assign out_data   = mem[rp];
	assign space_next = next_cnt < FULL;

	// next storage, indices and level
	always_comb begin
		next_mem = mem;
		next_wp  = wp;
		next_rp  = rp;
		next_cnt = cnt;
		push     = in_valid && in_ready;
		pop      = out_valid && out_ready;
		if (push) begin
			next_mem[wp] = in_data;
			next_wp      = bump(wp);
		end
		if (pop) begin
			next_rp = bump(rp);
		end
		if (push && !pop) begin
			next_cnt = cnt + 1'b1;
		end else if (pop && !push) begin
			next_cnt = cnt - 1'b1;
		end
	end

	// register state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			mem <= next_mem;
			wp  <= next_wp;
			rp  <= next_rp;
			cnt <= next_cnt;
		end
	end

endmodule
`default_nettype wire

// ==== rtl/mlp_split.sv ====
// splits a local write word into two memory beats, lower half first
`timescale 1ns/1ps
`default_nettype none
module mlp_split
	import mlp_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rst,
	input  wire mlp_word_s word,
	input  wire logic      word_valid,
	output logic           word_ready,
	output mlp_beat_s      beat,
	output logic           beat_valid,
	input  wire logic      beat_ready
);

	mlp_beat_s next_beat;
	logic      next_beat_valid;
	mlp_beat_s upper;           // second beat waiting
	mlp_beat_s next_upper;
	logic      upper_pend;      // second beat still owed
	logic      next_upper_pend;
	logic      free;            // beat register free this edge

	assign free       = !beat_valid || beat_ready;
	assign word_ready = free && !upper_pend;

	// next beat and held upper half
	always_comb begin
		next_beat       = beat;
		next_beat_valid = beat_valid;
		next_upper      = upper;
		next_upper_pend = upper_pend;
		if (free) begin
			next_beat_valid = 1'b0;
		end
		if (free && upper_pend) begin
			// second beat of the word
			next_beat       = upper;
			next_beat_valid = 1'b1;
			next_upper_pend = 1'b0;
		end else if (word_valid && word_ready) begin
			// lower half and lower mask bits go first
			next_beat.data             = word.data[DQ_W-1:0];
			next_beat.memory_data_mask = mlp_dm_of(word.mask[DM_W-1:0]);
			next_upper.data             = word.data[LW_W-1:DQ_W];
			next_upper.memory_data_mask = mlp_dm_of(word.mask[LM_W-1:DM_W]);
			next_beat_valid = 1'b1;
			next_upper_pend = 1'b1;
		end
	end

	// register beats
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			beat       <= '0;
			beat_valid <= 1'b0;
			upper      <= '0;
			upper_pend <= 1'b0;
		end else begin
			beat       <= next_beat;
			beat_valid <= next_beat_valid;
			upper      <= next_upper;
			upper_pend <= next_upper_pend;
		end
	end

endmodule
`default_nettype wire

// ==== testbench/mlp_port_properties.sv ====
// timing assertions on the ports of the local request port
`timescale 1ns/1ps
`default_nettype none
module mlp_port_properties
	import mlp_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ctrl_reset_n,
	input  wire logic              user_refresh_en,
	input  wire logic              write_req,
	input  wire logic              read_req,
	input  wire logic              burst_begin,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic [CNT_W-1:0]  burst_count,
	input  wire logic              refresh_req,
	input  wire logic [RANK_W-1:0] refresh_rank,
	input  wire logic              ready,
	input  wire logic              refresh_ack,
	input  wire mlp_cmd_s          cmd,
	input  wire logic              cmd_valid,
	input  wire logic              cmd_ready,
	input  wire mlp_beat_s         mem_beat,
	input  wire logic              mem_beat_valid,
	input  wire logic              mem_beat_ready
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	AST_HELD_NOT_READY: assert property (!$past(ctrl_reset_n) |-> !ready)
		else $error("ready high while controller held in reset");
	AST_READ_CMD: assert property (ready && read_req && !write_req && burst_begin && !refresh_req
		|=> cmd_valid && cmd.kind == CMD_READ && cmd.addr == $past(address))
		else $error("taken read start gave no read command");
	AST_WRITE_CMD: assert property (ready && write_req && burst_begin && !refresh_req && !cmd_valid
		|=> cmd_valid && cmd.kind == CMD_WRITE && cmd.count == ($past(burst_count) == 7'h00 ? 7'h01
		: $past(burst_count) > 7'h40 ? 7'h40 : $past(burst_count)))
		else $error("taken write start gave wrong write command");
	AST_ACK_CMD: assert property (refresh_ack |-> cmd_valid && cmd.kind == CMD_REFRESH
		&& cmd.ranks == $past(refresh_rank))
		else $error("refresh ack without matching refresh command");
	AST_ACK_CAUSE: assert property (refresh_ack |-> $past(refresh_req) && $past(user_refresh_en)
		&& $past(ctrl_reset_n))
		else $error("refresh issued without a user request");
	AST_REFRESH_FIRST: assert property ($rose(refresh_req) && user_refresh_en && refresh_rank != 2'h0
		&& ctrl_reset_n && ready && !write_req && !read_req |=> !ready)
		else $error("new requests still taken with refresh pending");
	AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
		else $error("command changed before it was taken");
	AST_BEAT_HOLD: assert property (mem_beat_valid && !mem_beat_ready
		|=> mem_beat_valid && $stable(mem_beat))
		else $error("memory beat changed before it was taken");
endmodule
`default_nettype wire

// ==== testbench/mlp_master_model.sv ====
// behavioural user master issuing burst requests into the port
`timescale 1ns/1ps
`default_nettype none
module mlp_master_model
	import mlp_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         ready,
	output logic              write_req,
	output logic              read_req,
	output logic              burst_begin,
	output logic [ADDR_W-1:0] address,
	output logic [LW_W-1:0]   write_data,
	output logic [LM_W-1:0]   write_byte_mask,
	output logic [CNT_W-1:0]  burst_count,
	output logic              auto_precharge_req
);
	// idle values at time zero
	initial begin
		write_req = 1'b0;
		read_req = 1'b0;
		burst_begin = 1'b0;
		address = '0;
		write_data = '0;
		write_byte_mask = '0;
		burst_count = 7'h01;
		auto_precharge_req = 1'b0;
	end

	// one burst; signals held until each beat is taken
	task automatic issue(input logic wr, input logic [CNT_W-1:0] cnt, input logic [LW_W-1:0] d,
		input logic [LM_W-1:0] m, input logic [ADDR_W-1:0] a, input logic ap, output logic ok);
		int n;
		logic tk;
		n = !wr ? 1 : cnt == 7'h00 ? 1 : cnt > 7'h40 ? 64 : int'(cnt);
		ok = 1'b0;
		@(negedge clock);
		write_req = wr;
		read_req = !wr;
		burst_begin = 1'b1;
		address = a;
		write_data = d;
		write_byte_mask = m;
		burst_count = cnt;
		auto_precharge_req = ap;
		for (int t = 0; t < 400 && !ok; t++) begin
			// ready is a flop: its value now is what the next rising edge sees
			tk = (ready === 1'b1);
			@(negedge clock);
			if (tk) begin
				n--;
				ok = (n == 0);
				burst_begin = 1'b0;
				burst_count = ~cnt;
				write_data = write_data + 32'h01010101;
			end
		end
		// released lines keep changing, never the last value
		write_req = 1'b0;
		read_req = 1'b0;
		address = ~address;
		write_data = ~write_data;
	endtask
endmodule
`default_nettype wire

// ==== testbench/mlp_port_bench.sv ====
// self-checking bench of the local request port
`timescale 1ns/1ps
`default_nettype none
module mlp_port_bench
	import mlp_pkg::*;
;
	logic              clock, rst, ctrl_reset_n, user_refresh_en, refresh_req, cmd_ready;
	logic              mem_beat_ready, ready, refresh_ack, cmd_valid, mem_beat_valid;
	logic              write_req, read_req, burst_begin, auto_precharge_req;
	logic [RANK_W-1:0] refresh_rank;
	logic [ADDR_W-1:0] address;
	logic [LW_W-1:0]   write_data;
	logic [LM_W-1:0]   write_byte_mask;
	logic [CNT_W-1:0]  burst_count;
	mlp_cmd_s          cmd;
	mlp_beat_s         mem_beat;
	int                failures, comparisons, acks, stalls;
	mlp_cmd_s          cmds[$];  // commands taken by the controller
	mlp_beat_s         beats[$]; // memory beats taken

	mlp_port mlp_port_i (.clock, .rst, .ctrl_reset_n, .user_refresh_en, .write_req, .read_req,
		.burst_begin, .address, .write_data, .write_byte_mask, .burst_count, .auto_precharge_req,
		.refresh_req, .refresh_rank, .ready, .refresh_ack, .cmd, .cmd_valid, .cmd_ready,
		.mem_beat, .mem_beat_valid, .mem_beat_ready);
	mlp_master_model mlp_master_model_i (.clock, .ready, .write_req, .read_req, .burst_begin,
		.address, .write_data, .write_byte_mask, .burst_count, .auto_precharge_req);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// collect what the far sides take
	always @(posedge clock) begin
		if (mem_beat_valid === 1'b1 && mem_beat_ready)
			beats.push_back(mem_beat);
		if (cmd_valid === 1'b1 && cmd_ready)
			cmds.push_back(cmd);
		if (refresh_ack === 1'b1)
			acks++;
		if (write_req && ready === 1'b0 && !rst)
			stalls++;
	end

	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_beat(input mlp_beat_s got, input mlp_beat_s exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t beat %h exp %h", $time, got, exp);
		end
	endtask

	// bounded wait on a queue length
	task automatic wait_for(input int n, input bit on_beats);
		for (int t = 0; t < 300 && (on_beats ? beats.size() : cmds.size()) < n; t++)
			@(negedge clock);
		if ((on_beats ? beats.size() : cmds.size()) < n) begin
			failures++;
			give_verdict();
		end
	endtask

	// write burst against a stalled command slot and beat sink
	task automatic sc_write_stall();
		logic ok;
		logic [LW_W-1:0] w;
		int c0, b0;
		c0 = cmds.size();
		b0 = beats.size();
		cmd_ready = 1'b0;
		mem_beat_ready = 1'b0;
		fork
			mlp_master_model_i.issue(1'b1, 7'h04, 32'h22334455, 4'hc, 24'h000100, 1'b0, ok);
			begin
				repeat (12) @(negedge clock);
				cmd_ready = 1'b1;
				repeat (6) @(negedge clock);
				mem_beat_ready = 1'b1;
			end
		join
		wait_for(b0 + 8, 1'b1);
		chk_val(ok, 1);
		chk_val(stalls != 0, 1);
		chk_val({cmds[c0].kind, cmds[c0].addr, cmds[c0].count, cmds[c0].autopch},
			{CMD_WRITE, 24'h000100, 7'h04, 1'b0});
		for (int k = 0; k < 4; k++) begin
			w = 32'h22334455 + k * 32'h01010101;
			chk_beat(beats[b0 + 2 * k], {w[15:0], 2'b11});
			chk_beat(beats[b0 + 2 * k + 1], {w[31:16], 2'b00});
		end
	endtask

	// reads at boundary counts; mask set but no beats
	task automatic sc_reads();
		logic ok;
		int c0, b0;
		logic [CNT_W-1:0] cin [4] = '{7'h00, 7'h02, 7'h40, 7'h7f};
		logic [CNT_W-1:0] cex [4] = '{7'h01, 7'h02, 7'h40, 7'h40};
		b0 = beats.size();
		for (int i = 0; i < 4; i++) begin
			c0 = cmds.size();
			mlp_master_model_i.issue(1'b0, cin[i], 32'h0, 4'hf, 24'h000200 + i, 1'b1, ok);
			wait_for(c0 + 1, 1'b0);
			chk_val({cmds[c0].kind, cmds[c0].addr, cmds[c0].count, cmds[c0].autopch},
				{CMD_READ, 24'(24'h000200 + i), cex[i], 1'b1});
		end
		repeat (10) @(negedge clock);
		chk_val(beats.size(), b0);
	endtask

	// two back to back refreshes, then requests never served
	task automatic sc_refresh();
		int n, a0, c0;
		c0 = cmds.size();
		n = 0;
		user_refresh_en = 1'b1;
		refresh_rank = 2'b10;
		refresh_req = 1'b1;
		for (int t = 0; t < 100 && n < 2; t++) begin
			@(negedge clock);
			if (refresh_ack === 1'b1)
				n++;
		end
		refresh_req = 1'b0;
		repeat (8) @(negedge clock);
		chk_val(cmds.size(), c0 + 2);
		for (int i = 0; i < 2; i++)
			chk_val({cmds[c0 + i].kind, cmds[c0 + i].ranks}, {CMD_REFRESH, 2'b10});
		a0 = acks;
		refresh_rank = 2'b00;
		refresh_req = 1'b1;
		repeat (20) @(negedge clock);
		refresh_rank = 2'b01;
		user_refresh_en = 1'b0;
		repeat (20) @(negedge clock);
		chk_val(ready, 1);
		refresh_req = 1'b0;
		chk_val(acks, a0);
	endtask

	// controller reset blocks requests and refresh
	task automatic sc_ctrl_reset();
		int a0;
		a0 = acks;
		ctrl_reset_n = 1'b0;
		user_refresh_en = 1'b1;
		refresh_rank = 2'b11;
		refresh_req = 1'b1;
		repeat (6) @(negedge clock);
		chk_val(ready, 0);
		refresh_req = 1'b0;
		ctrl_reset_n = 1'b1;
		repeat (3) @(negedge clock);
		chk_val(ready, 1);
		chk_val(acks, a0);
	endtask

	initial begin
		rst = 1'b1;
		ctrl_reset_n = 1'b1;
		user_refresh_en = 1'b0;
		refresh_req = 1'b0;
		refresh_rank = 2'b00;
		cmd_ready = 1'b1;
		mem_beat_ready = 1'b1;
		failures = 0;
		comparisons = 0;
		acks = 0;
		stalls = 0;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		sc_write_stall();
		sc_reads();
		sc_refresh();
		sc_ctrl_reset();
		give_verdict();
	end
endmodule

bind mlp_port mlp_port_properties mlp_port_properties_i (.clock, .rst, .ctrl_reset_n,
	.user_refresh_en, .write_req, .read_req, .burst_begin, .address, .burst_count, .refresh_req,
	.refresh_rank, .ready, .refresh_ack, .cmd, .cmd_valid, .cmd_ready, .mem_beat,
	.mem_beat_valid, .mem_beat_ready);
`default_nettype wire
